// file: core/access_system_regs.sv
// Operation
// - Decoded user-row-write key sets its key status flag.
// - NVM key flag set on decode, cleared as programming starts and allowed flag set.
// - Chip-erase key flag set on decode, cleared by the erase reset request.
// - Writing 0x59 asserts system reset, 0x00 releases; other codes not written.
// - Reset request leaves this debug logic running.
// - Clock select 1=16 MHz, 2=8 MHz, 3=4 MHz default, 0 reserved.
// - Writing one to user-row-done starts user row flash programming.
// - User-row-done writes take effect only after user-row key decode.
// - Clock request bit holds the system clock on through sleep; zero drops it.
// - Clock request clears on link disable, sets on programming-mode enable.
// - Reset-active flag shows system reset, including requested reset; read clears it.
// - In-sleep flag reads one while system sleeps in Idle or deeper.
// - NVM-programming-allowed flag set when programming may begin.
// - User-row-programming-allowed flag set when user row programming may begin.
// - Lock flag resets to one, reads zero after an erase clears the lock.
// - CRC status is one-hot: off, busy, good, failed.
// - Registers reachable only via debug link instructions, never the CPU.
// - Link disable clears decoded keys, link settings and clock request.
`timescale 1ns/1ps
`default_nettype none
module access_system_regs (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// Access port from the link instruction decoder
	input  wire logic       acc_wr,
	input  wire logic       acc_rd,
	input  wire logic [3:0] acc_addr,
	input  wire logic [7:0] acc_wdata,
	output logic      [7:0] acc_rdata,
	// Key decoder and link control
	input  wire logic       key_urow_decoded,
	input  wire logic       key_nvm_decoded,
	input  wire logic       key_erase_decoded,
	input  wire logic       link_disable,
	input  wire logic       link_enable_prog,
	// Programming sequencer
	input  wire logic       nvm_prog_start,
	input  wire logic       urow_prog_start,
	// System domain state, asynchronous
	input  wire logic       sys_in_reset,
	input  wire logic       sys_in_sleep,
	input  wire logic       sys_locked,
	input  wire logic [2:0] sys_crc_status,
	// Controls towards the system
	output logic            sys_reset_req,
	output logic            system_clock_request,
	output logic      [1:0] link_clock_select,
	output logic            user_row_done
);

	typedef struct packed {
		logic       rst_s1;
		logic       rst_s2;
		logic       sleep_s1;
		logic       sleep_s2;
		logic       lock_s1;
		logic       lock_s2;
		logic [2:0] crc_s1;
		logic [2:0] crc_s2;
		logic       key_urow;
		logic       key_nvm;
		logic       key_erase;
		logic       rst_hold;
		logic [1:0] clk_sel;
		logic       clk_req;
		logic       urow_done;
		logic       nvm_allowed;
		logic       urow_allowed;
		logic       system_reset_active;
		logic [7:0] rdata;
	} state_s;

	state_s state_q;
	state_s state_d;

	logic wr_key;
	logic wr_rst;
	logic wr_clk;
	logic wr_ctl;
	logic rd_sts;
	logic [7:0] rd_mux;

	assign wr_key = acc_wr && (acc_addr == access_system_pkg::OFS_KEY_STATUS);
	assign wr_rst = acc_wr && (acc_addr == access_system_pkg::OFS_RESET_REQ);
	assign wr_clk = acc_wr && (acc_addr == access_system_pkg::OFS_LINK_CLOCK);
	assign wr_ctl = acc_wr && (acc_addr == access_system_pkg::OFS_SYS_CONTROL);
	assign rd_sts = acc_rd && (acc_addr == access_system_pkg::OFS_SYS_STATUS);

	always_comb
	begin
		rd_mux = 8'h00;
		case (acc_addr)
			access_system_pkg::OFS_KEY_STATUS:
			begin
				rd_mux[access_system_pkg::KEY_UROW_BIT]  = state_q.key_urow;
				rd_mux[access_system_pkg::KEY_NVM_BIT]   = state_q.key_nvm;
				rd_mux[access_system_pkg::KEY_ERASE_BIT] = state_q.key_erase;
			end
			access_system_pkg::OFS_RESET_REQ:
				rd_mux = state_q.rst_hold ? access_system_pkg::RST_CODE_RESET
					: access_system_pkg::RST_CODE_RUN;
			access_system_pkg::OFS_LINK_CLOCK:
				rd_mux[1:0] = state_q.clk_sel;
			access_system_pkg::OFS_SYS_CONTROL:
				rd_mux[access_system_pkg::CTL_CLK_REQ_BIT] = state_q.clk_req;
			access_system_pkg::OFS_SYS_STATUS:
			begin
				rd_mux[access_system_pkg::STS_SYSTEM_RESET_ACTIVE_BIT] = state_q.system_reset_active;
				rd_mux[access_system_pkg::STS_SLEEP_BIT]  = state_q.sleep_s2;
				rd_mux[access_system_pkg::STS_NVM_BIT]    = state_q.nvm_allowed;
				rd_mux[access_system_pkg::STS_UROW_BIT]   = state_q.urow_allowed;
				rd_mux[access_system_pkg::STS_LOCK_BIT]   = state_q.lock_s2;
			end
			access_system_pkg::OFS_CRC_STATUS:
				rd_mux[2:0] = state_q.crc_s2;
			default:
				rd_mux = 8'h00;
		endcase
	end

	always_comb
	begin
		state_d = state_q;

		// System state crosses in through two flops each
		state_d.rst_s1   = sys_in_reset;
		state_d.rst_s2   = state_q.rst_s1;
		state_d.sleep_s1 = sys_in_sleep;
		state_d.sleep_s2 = state_q.sleep_s1;
		state_d.lock_s1  = sys_locked;
		state_d.lock_s2  = state_q.lock_s1;
		state_d.crc_s1   = sys_crc_status;
		state_d.crc_s2   = state_q.crc_s1;

		state_d.urow_done = 1'b0;
		if (acc_rd)
			state_d.rdata = rd_mux;

		if (wr_key && acc_wdata[access_system_pkg::KEY_UROW_BIT])
		begin
			state_d.key_urow     = 1'b0;
			state_d.urow_allowed = 1'b0;
		end

		if (wr_rst && (acc_wdata == access_system_pkg::RST_CODE_RESET))
		begin
			state_d.rst_hold    = 1'b1;
			state_d.key_erase   = 1'b0;
			state_d.nvm_allowed = 1'b0;
		end
		else if (wr_rst && (acc_wdata == access_system_pkg::RST_CODE_RUN))
			state_d.rst_hold = 1'b0;

		if (wr_clk && (acc_wdata[1:0] != access_system_pkg::CLK_SEL_RESERVED))
			state_d.clk_sel = acc_wdata[1:0];

		if (wr_ctl)
		begin
			state_d.clk_req = acc_wdata[access_system_pkg::CTL_CLK_REQ_BIT];
			if (state_q.key_urow && acc_wdata[access_system_pkg::CTL_UROW_DONE_BIT])
			begin
				state_d.urow_done    = 1'b1;
				state_d.urow_allowed = 1'b0;
			end
		end

		if (nvm_prog_start)
		begin
			state_d.key_nvm     = 1'b0;
			state_d.nvm_allowed = 1'b1;
		end

		if (urow_prog_start && state_q.key_urow)
			state_d.urow_allowed = 1'b1;

		// Decoded keys win over any clear in the same cycle except link disable
		// user row, NVM and chip-erase keys
		if (key_urow_decoded)
			state_d.key_urow = 1'b1;
		if (key_nvm_decoded)
			state_d.key_nvm = 1'b1;
		if (key_erase_decoded)
			state_d.key_erase = 1'b1;

		if (rd_sts)
			state_d.system_reset_active = 1'b0;
		if (state_q.rst_s2 || state_q.rst_hold)
			state_d.system_reset_active = 1'b1;

		if (link_enable_prog)
			state_d.clk_req = 1'b1;

		// disable drops keys and link settings
		if (link_disable)
		begin
			state_d.key_urow     = 1'b0;
			state_d.key_nvm      = 1'b0;
			state_d.key_erase    = 1'b0;
			state_d.clk_sel      = access_system_pkg::CLK_SEL_RESET;
			state_d.clk_req      = 1'b0;
			state_d.urow_done    = 1'b0;
			state_d.urow_allowed = 1'b0;
		end
	end

	// only the link's own reset clears this state
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q         <= '0;
			state_q.lock_s1 <= access_system_pkg::STS_LOCK_RESET;
			state_q.lock_s2 <= access_system_pkg::STS_LOCK_RESET;
			state_q.clk_sel <= access_system_pkg::CLK_SEL_RESET;
		end
		else
			state_q <= state_d;
	end

	assign acc_rdata            = state_q.rdata;
	assign sys_reset_req        = state_q.rst_hold;
	assign system_clock_request = state_q.clk_req;
	assign link_clock_select    = state_q.clk_sel;
	assign user_row_done        = state_q.urow_done;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	property p_key_urow_set;
		key_urow_decoded && !link_disable |=> state_q.key_urow;
	endproperty
	a_key_urow_set: assert property (p_key_urow_set)
		else $error("user row key flag not set after decode");

	property p_nvm_start;
		nvm_prog_start && !key_nvm_decoded && !link_disable
			|=> !state_q.key_nvm && state_q.nvm_allowed;
	endproperty
	a_nvm_start: assert property (p_nvm_start)
		else $error("NVM key not cleared or allowed flag not set");

	property p_erase_clear;
		wr_rst && acc_wdata == access_system_pkg::RST_CODE_RESET && !key_erase_decoded
			|=> !state_q.key_erase;
	endproperty
	a_erase_clear: assert property (p_erase_clear)
		else $error("erase key survived reset request");

	property p_rst_codes;
		wr_rst && acc_wdata == access_system_pkg::RST_CODE_RESET
			|=> sys_reset_req;
	endproperty
	a_rst_codes: assert property (p_rst_codes)
		else $error("reset request code did not assert reset");

	property p_rst_release;
		sys_reset_req && wr_rst && acc_wdata == access_system_pkg::RST_CODE_RUN
			|=> !sys_reset_req;
	endproperty
	a_rst_release: assert property (p_rst_release)
		else $error("run code did not release reset");

	property p_rst_reserved;
		wr_rst && acc_wdata != access_system_pkg::RST_CODE_RESET
			&& acc_wdata != access_system_pkg::RST_CODE_RUN |=> $stable(sys_reset_req);
	endproperty
	a_rst_reserved: assert property (p_rst_reserved)
		else $error("reserved reset code changed reset state");

	property p_clk_sel;
		wr_clk && acc_wdata[1:0] == access_system_pkg::CLK_SEL_RESERVED
			&& !link_disable |=> $stable(link_clock_select);
	endproperty
	a_clk_sel: assert property (p_clk_sel)
		else $error("reserved clock select accepted");

	property p_urow_gate;
		wr_ctl && !state_q.key_urow |=> !user_row_done;
	endproperty
	a_urow_gate: assert property (p_urow_gate)
		else $error("user row done accepted without key");

	property p_urow_start;
		wr_ctl && state_q.key_urow && acc_wdata[access_system_pkg::CTL_UROW_DONE_BIT]
			&& !link_disable |=> user_row_done ##1 !user_row_done;
	endproperty
	a_urow_start: assert property (p_urow_start)
		else $error("user row done pulse wrong");

	property p_disable;
		link_disable |=> !system_clock_request && !state_q.key_urow
			&& link_clock_select == access_system_pkg::CLK_SEL_RESET;
	endproperty
	a_disable: assert property (p_disable)
		else $error("link disable left state behind");

	property p_system_reset_active;
		sys_reset_req |=> state_q.system_reset_active;
	endproperty
	a_system_reset_active: assert property (p_system_reset_active)
		else $error("reset active flag missing during requested reset");

	// Enable must leave the clock held on even if software never wrote it
	property p_clk_req_enable;
		link_enable_prog && !link_disable |=> system_clock_request;
	endproperty
	a_clk_req_enable: assert property (p_clk_req_enable)
		else $error("clock request not set on programming enable");

	property p_urow_allowed;
		urow_prog_start && state_q.key_urow && !link_disable |=> state_q.urow_allowed;
	endproperty
	a_urow_allowed: assert property (p_urow_allowed)
		else $error("user row allowed flag not set");

	property p_nvm_end;
		wr_rst && acc_wdata == access_system_pkg::RST_CODE_RESET && !nvm_prog_start
			|=> !state_q.nvm_allowed;
	endproperty
	a_nvm_end: assert property (p_nvm_end)
		else $error("programming allowed flag survived reset request");

endmodule : access_system_regs
`default_nettype wire

// file: include/access_system_pkg.sv
`default_nettype none
package access_system_pkg;
	// Register offsets on the link's access-layer space
	localparam logic [3:0] OFS_KEY_STATUS  = 4'h7;
	localparam logic [3:0] OFS_RESET_REQ   = 4'h8;
	localparam logic [3:0] OFS_LINK_CLOCK  = 4'h9;
	localparam logic [3:0] OFS_SYS_CONTROL = 4'ha;
	localparam logic [3:0] OFS_SYS_STATUS  = 4'hb;
	localparam logic [3:0] OFS_CRC_STATUS  = 4'hc;

	// Key status fields
	localparam int KEY_UROW_BIT  = 5;
	localparam int KEY_NVM_BIT   = 4;
	localparam int KEY_ERASE_BIT = 3;

	// Reset request codes
	localparam logic [7:0] RST_CODE_RUN   = 8'h00;
	localparam logic [7:0] RST_CODE_RESET = 8'h59;

	// Link clock select codes
	localparam logic [1:0] CLK_SEL_RESERVED = 2'h0;
	localparam logic [1:0] CLK_SEL_16MHZ    = 2'h1;
	localparam logic [1:0] CLK_SEL_8MHZ     = 2'h2;
	localparam logic [1:0] CLK_SEL_4MHZ     = 2'h3;
	localparam logic [1:0] CLK_SEL_RESET    = CLK_SEL_4MHZ;

	// System control fields
	localparam int CTL_UROW_DONE_BIT = 1;
	localparam int CTL_CLK_REQ_BIT   = 0;

	// System status fields
	localparam int STS_SYSTEM_RESET_ACTIVE_BIT  = 5;
	localparam int STS_SLEEP_BIT   = 4;
	localparam int STS_NVM_BIT     = 3;
	localparam int STS_UROW_BIT    = 2;
	localparam int STS_LOCK_BIT    = 0;
	localparam logic STS_LOCK_RESET = 1'b1;

	// CRC status codes, one-hot
	localparam logic [2:0] CRC_OFF  = 3'h0;
	localparam logic [2:0] CRC_BUSY = 3'h1;
	localparam logic [2:0] CRC_OK   = 3'h2;
	localparam logic [2:0] CRC_FAIL = 3'h4;
endpackage : access_system_pkg
`default_nettype wire

// file: bench/system_domain_model.sv
`timescale 1ns/1ps
`default_nettype none
module system_domain_model (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic resetn,
	// Reset request from the access layer
	input  wire logic sys_reset_req,
	// System reset state back to the access layer
	output logic      sys_in_reset
);
	// only system resets
	// A cycle of lag, as a reset tree would add
	always_ff @(posedge clk_sys or negedge resetn)
		if (!resetn)
			sys_in_reset <= 1'h0;
		else
			sys_in_reset <= sys_reset_req;
endmodule : system_domain_model
`default_nettype wire

// file: bench/debug_access_system_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module debug_access_system_regs_tb;
	logic       clk_sys = 1'h0, resetn = 1'h0, acc_wr = 1'h0, acc_rd = 1'h0;
	logic [3:0] acc_addr = 4'h0;
	logic [7:0] acc_wdata = 8'h00, rd_q, acc_rdata;
	logic       key_urow_decoded = 1'h0, key_nvm_decoded = 1'h0, key_erase_decoded = 1'h0;
	logic       link_disable = 1'h0, link_enable_prog = 1'h0, sys_in_sleep = 1'h0;
	logic       nvm_prog_start = 1'h0, urow_prog_start = 1'h0, sys_locked = 1'h1;
	logic [2:0] sys_crc_status = 3'h0;
	logic [1:0] link_clock_select;
	logic       sys_in_reset, sys_reset_req, system_clock_request, user_row_done;
	int         failures = 0, checked = 0, cycles = 0, pulses = 0;

	access_system_regs DUT (.clk_sys, .resetn, .acc_wr, .acc_rd, .acc_addr, .acc_wdata,
		.acc_rdata, .key_urow_decoded, .key_nvm_decoded, .key_erase_decoded, .link_disable,
		.link_enable_prog, .nvm_prog_start, .urow_prog_start, .sys_in_reset, .sys_in_sleep,
		.sys_locked, .sys_crc_status, .sys_reset_req, .system_clock_request,
		.link_clock_select, .user_row_done);
	system_domain_model sys_model (.clk_sys, .resetn, .sys_reset_req, .sys_in_reset);

	always #50 clk_sys = ~clk_sys;

	// Pulse counter, and a ceiling well above the run length
	// Sampled on the falling edge, away from the edge that launches the pulse
	always @(negedge clk_sys)
	begin
		cycles++;
		if (user_row_done === 1'h1)
			pulses++;
		if (cycles == 4000)
		begin
			failures++;
			end_sim();
		end
	end

	task automatic end_sim;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		acc_wr = 1'h1;
		acc_addr = a;
		acc_wdata = d;
		@(negedge clk_sys);
		acc_wr = 1'h0;
	endtask : wr

	task automatic rd(input logic [3:0] a);
		@(negedge clk_sys);
		acc_rd = 1'h1;
		acc_addr = a;
		@(negedge clk_sys);
		acc_rd = 1'h0;
		rd_q = acc_rdata;
	endtask : rd

	task automatic pulse(ref logic s);
		@(negedge clk_sys);
		s = 1'h1;
		@(negedge clk_sys);
		s = 1'h0;
	endtask : pulse

	// Async inputs pass two flops before they show
	task automatic settle;
		repeat (4) @(negedge clk_sys);
	endtask : settle

	task automatic t_reset;
		rd(4'h7);
		chk(rd_q, 8'h00);
		rd(4'h8);
		chk(rd_q, 8'h00);
		rd(4'h9);
		chk(rd_q, 8'h03);
		rd(4'ha);
		chk(rd_q, 8'h00);
		rd(4'hb);
		chk(rd_q, 8'h01);
		rd(4'h0);
		chk(rd_q, 8'h00);
	endtask : t_reset

	task automatic t_clock_select;
		logic [1:0] code;
		logic [1:0] exp;
		for (int i = 1; i < 5; i++)
		begin
			code = i[1:0];
			// Reserved code 0 keeps the previous choice
			exp = (code == 2'h0) ? 2'h3 : code;
			wr(4'h9, {6'h00, code});
			rd(4'h9);
			chk(rd_q, {6'h00, exp});
			chk({6'h00, link_clock_select}, {6'h00, exp});
		end
	endtask : t_clock_select

	task automatic t_reset_req;
		wr(4'h9, 8'h02);
		pulse(key_erase_decoded);
		rd(4'h7);
		chk(rd_q, 8'h08);
		wr(4'h8, 8'h59);
		chk({7'h00, sys_reset_req}, 8'h01);
		rd(4'h7);
		chk(rd_q, 8'h00);
		wr(4'h8, 8'h12);
		rd(4'h8);
		chk(rd_q, 8'h59);
		settle();
		rd(4'hb);
		chk({7'h00, rd_q[5]}, 8'h01);
		chk({6'h00, link_clock_select}, 8'h02);
		wr(4'h8, 8'h00);
		chk({7'h00, sys_reset_req}, 8'h00);
		settle();
		rd(4'hb);
		rd(4'hb);
		chk({7'h00, rd_q[5]}, 8'h00);
	endtask : t_reset_req

	task automatic t_keys;
		int n;
		n = pulses;
		wr(4'ha, 8'h02);
		settle();
		chk(8'(pulses - n), 8'h00);
		pulse(key_urow_decoded);
		rd(4'h7);
		chk(rd_q, 8'h20);
		pulse(urow_prog_start);
		rd(4'hb);
		chk({7'h00, rd_q[2]}, 8'h01);
		n = pulses;
		wr(4'ha, 8'h02);
		settle();
		chk(8'(pulses - n), 8'h01);
		wr(4'h7, 8'h20);
		rd(4'h7);
		chk(rd_q, 8'h00);
		pulse(key_nvm_decoded);
		rd(4'h7);
		chk(rd_q, 8'h10);
		pulse(nvm_prog_start);
		rd(4'h7);
		chk(rd_q, 8'h00);
		rd(4'hb);
		chk({7'h00, rd_q[3]}, 8'h01);
		wr(4'h8, 8'h59);
		rd(4'hb);
		chk({7'h00, rd_q[3]}, 8'h00);
		wr(4'h8, 8'h00);
	endtask : t_keys

	task automatic t_clock_req;
		wr(4'ha, 8'h01);
		sys_in_sleep = 1'h1;
		settle();
		rd(4'hb);
		chk({7'h00, rd_q[4]}, 8'h01);
		chk({7'h00, system_clock_request}, 8'h01);
		wr(4'ha, 8'h00);
		chk({7'h00, system_clock_request}, 8'h00);
		sys_in_sleep = 1'h0;
		settle();
		rd(4'hb);
		chk({7'h00, rd_q[4]}, 8'h00);
		pulse(link_enable_prog);
		chk({7'h00, system_clock_request}, 8'h01);
		pulse(key_urow_decoded);
		pulse(key_nvm_decoded);
		pulse(key_erase_decoded);
		wr(4'h9, 8'h01);
		pulse(link_disable);
		chk({7'h00, system_clock_request}, 8'h00);
		chk({6'h00, link_clock_select}, 8'h03);
		rd(4'h7);
		chk(rd_q, 8'h00);
	endtask : t_clock_req

	task automatic t_status;
		logic [2:0] codes [4];
		codes = '{3'h0, 3'h1, 3'h2, 3'h4};
		sys_locked = 1'h0;
		foreach (codes[i])
		begin
			sys_crc_status = codes[i];
			settle();
			rd(4'hc);
			chk(rd_q, {5'h00, codes[i]});
		end
		rd(4'hb);
		chk({7'h00, rd_q[0]}, 8'h00);
	endtask : t_status

	initial
	begin
		repeat (10) @(negedge clk_sys);
		resetn = 1'h1;
		settle();
		t_reset();
		t_clock_select();
		t_reset_req();
		t_keys();
		t_clock_req();
		t_status();
		end_sim();
	end
endmodule : debug_access_system_regs_tb
`default_nettype wire
